// ===== lpt_consts.svh
// Purpose: Constants for the lane transceiver port
// Assumes: 50 MHz core clock
// Notes: Timing counts derive from times in ns
`ifndef LPT_CONSTS_SVH
`define LPT_CONSTS_SVH
`define LPT_WORD_BITS 32
`define LPT_LANE_BYTES 4
`define LPT_LANES_DEFAULT 4
`define LPT_FIFO_DEPTH 16
`define LPT_TX_STATUS_MIN 15
`define LPT_RX_STATUS_MIN 8
`define LPT_STAT_CNT_W 4
`define LPT_BUF_STAT_W 6
`define LPT_BUF_STAT_MAX 30
`define LPT_CLK_MHZ 50
`define LPT_GT_RESET_NS 200
`define LPT_GT_RESET_CYC ((`LPT_GT_RESET_NS * `LPT_CLK_MHZ + 999) / 1000)
`define LPT_TIMER_W 8
`define LPT_IDLE_CHAR 8'hbc
`endif

// ===== lpt_pkg.sv
// Purpose: Types for the lane transceiver port
// Assumes: Nothing beyond the constants header
// Notes: State codes are written out
package lpt_pkg;
   typedef enum logic [1:0] {
      lpt_st_reset = 2'b00,
      lpt_st_wait = 2'b01,
      lpt_st_bond = 2'b10,
      lpt_st_run = 2'b11
   } lpt_state_type;
endpackage : lpt_pkg

// ===== lpt_fifo_if.sv
// Purpose: Valid/ready word carrier between the port and its FIFO
// Assumes: One clock
// Notes: Word moves when valid and ready are both high
`timescale 1ns/100ps
interface lpt_fifo_if #(parameter int W = 8) ();
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : lpt_fifo_if

// ===== lpt_fifo.sv
// Purpose: Show-ahead FIFO for transmit words
// Assumes: Power-of-two depth, one clock
// Notes: Ready and valid come straight from flops
`timescale 1ns/100ps
module lpt_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   lpt_fifo_if.snk wr,
   lpt_fifo_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_bad_depth
         $error("lpt_fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic not_full_reg;
   logic not_empty_reg;
   logic push;
   logic pop;

   // Handshakes on both sides
   assign push = wr.valid & not_full_reg;
   assign pop = not_empty_reg & rd.ready;
   assign wr.ready = not_full_reg;
   assign rd.valid = not_empty_reg;
   assign rd.data = mem[rptr_reg];
   assign count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);

   // Storage write
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wptr_reg] <= wr.data;
      end
   end

   // Pointers, fill count and flags
   always_ff @(posedge clk) begin
      if (srst) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
         not_full_reg <= 1'b1;
         not_empty_reg <= 1'b0;
      end else if (ce) begin
         if (push) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= rptr_reg + 1'b1;
         end
         count_reg <= count_next;
         not_full_reg <= (count_next != (AW + 1)'(DEPTH));
         not_empty_reg <= (count_next != '0);
      end
   end
endmodule : lpt_fifo

// ===== lpt_lane_port.sv
// Purpose: Lane-facing port toward 8b/10b serial transceivers
// Assumes: Transceiver data on core_clk; reset request and done are asynchronous
// Notes: Receive data is marked valid only after every lane ends reset
`timescale 1ns/100ps
`include "lpt_consts.svh"

// Function
// R1: Buffer layer never presents an all-ones receive buffer status.
// R2: Buffer layer never presents status with low five bits all ones.
// R3: Status estimates free slots, saturating at 30.
// R4: Flow control runs transmitter-controlled while the mode input is high.
// R5: Transmit data goes out as one 32-bit word per lane, concatenated.
// R6: One transmit K flag per byte; bit n marks byte n.
// R7: One transmit inhibit bit per lane disables that lane's transmitter.
// R8: Transceivers deliver one 32-bit receive word per lane, concatenated.
// R9: Transceivers deliver one receive K flag per byte.
// R10: Transceivers deliver one comma flag per received byte.
// R11: A byte with a disparity error is treated as errored.
// R12: A byte failing 8b/10b decoding is treated as errored.
// R13: One bit per lane reports a received channel bonding sequence.
// R14: One bit per lane reports alignment with the bonding master lane.
// R15: One output enables channel bonding in the transceivers.
// R16: Transceivers raise a reset request whenever they need a reset.
// R17: The port drives a reset output toward the transceivers.
// R18: Transceivers report reset completion with one bit per lane.
// R19: Lane initialized only after 15 Status sent and 8 clean received.
// R20: On reset request, reset transceivers; ignore receive data until all lanes done.
module lpt_lane_port #(
   parameter int LANE_COUNT = `LPT_LANES_DEFAULT,
   parameter int FIFO_DEPTH = `LPT_FIFO_DEPTH,
   parameter int BUF_STAT_W = `LPT_BUF_STAT_W
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [32*LANE_COUNT-1:0] tx_word,
   input wire logic [4*LANE_COUNT-1:0] tx_word_k,
   input wire logic tx_word_valid,
   output wire logic tx_word_ready,
   input wire logic [LANE_COUNT-1:0] tx_lane_off,
   output logic [32*LANE_COUNT-1:0] gttx_data,
   output logic [4*LANE_COUNT-1:0] gttx_charisk,
   output logic [LANE_COUNT-1:0] gttx_inhibit,
   input wire logic [32*LANE_COUNT-1:0] gtrx_data,
   input wire logic [4*LANE_COUNT-1:0] gtrx_charisk,
   input wire logic [4*LANE_COUNT-1:0] gtrx_chariscomma,
   input wire logic [4*LANE_COUNT-1:0] gtrx_disperr,
   input wire logic [4*LANE_COUNT-1:0] gtrx_notintable,
   input wire logic [LANE_COUNT-1:0] gtrx_chanbondseq,
   input wire logic [LANE_COUNT-1:0] gtrx_chanisaligned,
   output logic gtrx_chanbonden,
   input wire logic gtrx_reset_req,
   output logic gtrx_reset,
   input wire logic [LANE_COUNT-1:0] gtrx_reset_done,
   output logic [32*LANE_COUNT-1:0] rx_word,
   output logic [4*LANE_COUNT-1:0] rx_word_k,
   output logic [4*LANE_COUNT-1:0] rx_word_comma,
   output logic [4*LANE_COUNT-1:0] rx_byte_err,
   output logic rx_word_valid,
   output logic [LANE_COUNT-1:0] rx_bond_seq,
   input wire logic [BUF_STAT_W-1:0] buf_stat_in,
   input wire logic tx_flow_control,
   output logic [BUF_STAT_W-1:0] buf_stat_out,
   output logic tx_flow_mode,
   input wire logic tx_status_sent,
   input wire logic [LANE_COUNT-1:0] rx_status_good,
   input wire logic [LANE_COUNT-1:0] rx_status_bad,
   output logic [LANE_COUNT-1:0] lane_initialized,
   output logic [1:0] port_state
);
   import lpt_pkg::*;

   localparam int TXW = 36 * LANE_COUNT;
   localparam int SCW = `LPT_STAT_CNT_W;
   localparam logic [`LPT_TIMER_W-1:0] RST_CYC = `LPT_TIMER_W'(`LPT_GT_RESET_CYC);
   localparam logic [SCW-1:0] TX_MIN = SCW'(`LPT_TX_STATUS_MIN);
   localparam logic [SCW-1:0] RX_MIN = SCW'(`LPT_RX_STATUS_MIN);
   localparam logic [BUF_STAT_W-1:0] STAT_MAX = BUF_STAT_W'(`LPT_BUF_STAT_MAX);

   // ****************************************
   // Parameter checks
   // ****************************************
   generate
      if (LANE_COUNT != 1 && LANE_COUNT != 2 && LANE_COUNT != 4) begin : g_bad_lanes
         $error("lpt_lane_port lane count must be 1, 2 or 4");
      end
      if (BUF_STAT_W < 5) begin : g_bad_stat
         $error("lpt_lane_port buffer status needs at least 5 bits");
      end
   endgenerate

   // All lanes report a level high
   function automatic logic all_lanes(input logic [LANE_COUNT-1:0] v);
      all_lanes = &v;
   endfunction : all_lanes

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic req_meta_reg;
   logic req_sync_reg;
   logic [LANE_COUNT-1:0] done_meta_reg;
   logic [LANE_COUNT-1:0] done_sync_reg;

   // Two flops on transceiver reset handshake levels
   always_ff @(posedge core_clk) begin
      if (srst) begin
         req_meta_reg <= 1'b0;
         req_sync_reg <= 1'b0;
         done_meta_reg <= '0;
         done_sync_reg <= '0;
      end else if (ce) begin
         req_meta_reg <= gtrx_reset_req;
         req_sync_reg <= req_meta_reg;
         done_meta_reg <= gtrx_reset_done;
         done_sync_reg <= done_meta_reg;
      end
   end

   // ****************************************
   // Transceiver reset and bonding sequence
   // ****************************************
   lpt_state_type state_reg;
   logic [`LPT_TIMER_W-1:0] timer_reg;
   logic run;

   assign run = (state_reg == lpt_st_run);

   // Reset pulse, wait for done, bond if more than one lane, then run
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= lpt_st_reset;
         timer_reg <= RST_CYC;
      end else if (ce) begin
         if (req_sync_reg && state_reg != lpt_st_reset) begin
            state_reg <= lpt_st_reset; // see R20
            timer_reg <= RST_CYC;
         end else begin
            case (state_reg)
               lpt_st_reset: begin
                  if (timer_reg <= `LPT_TIMER_W'(1)) begin
                     state_reg <= lpt_st_wait;
                  end else begin
                     timer_reg <= timer_reg - 1'b1;
                  end
               end
               lpt_st_wait: begin
                  if (all_lanes(done_sync_reg)) begin
                     state_reg <= (LANE_COUNT == 1) ? lpt_st_run : lpt_st_bond; // see R18
                  end
               end
               lpt_st_bond: begin
                  if (!all_lanes(done_sync_reg)) begin
                     state_reg <= lpt_st_wait;
                  end else if (all_lanes(gtrx_chanisaligned)) begin
                     state_reg <= lpt_st_run; // see R14
                  end
               end
               lpt_st_run: begin
                  if (!all_lanes(done_sync_reg)) begin
                     state_reg <= lpt_st_wait; // see R20
                  end else if (LANE_COUNT > 1 && !all_lanes(gtrx_chanisaligned)) begin
                     state_reg <= lpt_st_bond;
                  end
               end
               default: begin
                  state_reg <= lpt_st_reset;
               end
            endcase
         end
      end
   end

   // Reset and bonding outputs from state
   always_ff @(posedge core_clk) begin
      if (srst) begin
         gtrx_reset <= 1'b1;
         gtrx_chanbonden <= 1'b0;
         port_state <= 2'b00;
      end else if (ce) begin
         gtrx_reset <= (state_reg == lpt_st_reset) && !(timer_reg <= `LPT_TIMER_W'(1)); // see R17
         gtrx_chanbonden <= (LANE_COUNT > 1) && (state_reg[1] == 1'b1); // see R15
         port_state <= state_reg;
      end
   end

   // ****************************************
   // Transmit path
   // ****************************************
   lpt_fifo_if #(.W(TXW)) fifo_in ();
   lpt_fifo_if #(.W(TXW)) fifo_out ();

   assign fifo_in.data = {tx_word_k, tx_word};
   assign fifo_in.valid = tx_word_valid;
   assign tx_word_ready = fifo_in.ready;
   assign fifo_out.ready = run;

   lpt_fifo #(
      .W(TXW),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .clk(core_clk),
      .srst(srst),
      .ce(ce),
      .wr(fifo_in),
      .rd(fifo_out)
   );

   // Per-lane word, flags and inhibit; idle comma when nothing queued
   genvar ln;
   generate
      for (ln = 0; ln < LANE_COUNT; ln++) begin : g_tx_lane
         always_ff @(posedge core_clk) begin
            if (srst) begin
               gttx_data[32*ln +: 32] <= {24'h000000, `LPT_IDLE_CHAR};
               gttx_charisk[4*ln +: 4] <= 4'h1;
               gttx_inhibit[ln] <= 1'b0;
            end else if (ce) begin
               if (run && fifo_out.valid) begin
                  gttx_data[32*ln +: 32] <= fifo_out.data[32*ln +: 32]; // see R5
                  gttx_charisk[4*ln +: 4] <= fifo_out.data[32*LANE_COUNT+4*ln +: 4]; // see R6
               end else begin
                  gttx_data[32*ln +: 32] <= {24'h000000, `LPT_IDLE_CHAR};
                  gttx_charisk[4*ln +: 4] <= 4'h1;
               end
               gttx_inhibit[ln] <= tx_lane_off[ln]; // see R7
            end
         end
      end
   endgenerate

   // ****************************************
   // Receive path
   // ****************************************
   // Receive word, flags and per-byte error
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_word <= '0;
         rx_word_k <= '0;
         rx_word_comma <= '0;
         rx_byte_err <= '0;
         rx_bond_seq <= '0;
         rx_word_valid <= 1'b0;
      end else if (ce) begin
         rx_word <= gtrx_data; // see R8
         rx_word_k <= gtrx_charisk; // see R9
         rx_word_comma <= gtrx_chariscomma; // see R10
         rx_byte_err <= gtrx_disperr | gtrx_notintable; // see R11 see R12
         rx_bond_seq <= gtrx_chanbondseq; // see R13
         rx_word_valid <= run; // see R20
      end
   end

   // ****************************************
   // Buffer status and flow mode
   // ****************************************
   // Clamp status so reserved codes never pass on
   always_ff @(posedge core_clk) begin
      if (srst) begin
         buf_stat_out <= '0;
         tx_flow_mode <= 1'b0;
      end else if (ce) begin
         buf_stat_out <= (buf_stat_in > STAT_MAX) ? STAT_MAX : buf_stat_in; // see R1 see R2 see R3
         tx_flow_mode <= tx_flow_control; // see R4
      end
   end

   // ****************************************
   // Initialization counts
   // ****************************************
   logic [SCW-1:0] tx_stat_cnt_reg;

   // Saturating count of Status symbols sent
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_stat_cnt_reg <= '0;
      end else if (ce) begin
         if (!run) begin
            tx_stat_cnt_reg <= '0;
         end else if (tx_status_sent && tx_stat_cnt_reg < TX_MIN) begin
            tx_stat_cnt_reg <= tx_stat_cnt_reg + 1'b1;
         end
      end
   end

   // Per-lane clean Status count; an errored one restarts it
   generate
      for (ln = 0; ln < LANE_COUNT; ln++) begin : g_init_lane
         logic [SCW-1:0] rx_cnt_reg;
         always_ff @(posedge core_clk) begin
            if (srst) begin
               rx_cnt_reg <= '0;
               lane_initialized[ln] <= 1'b0;
            end else if (ce) begin
               if (!run || rx_status_bad[ln]) begin
                  rx_cnt_reg <= '0;
               end else if (rx_status_good[ln] && rx_cnt_reg < RX_MIN) begin
                  rx_cnt_reg <= rx_cnt_reg + 1'b1;
               end
               lane_initialized[ln] <= run && !rx_status_bad[ln]
                  && (tx_stat_cnt_reg >= TX_MIN) && (rx_cnt_reg >= RX_MIN); // see R19
            end
         end
      end
   endgenerate
endmodule : lpt_lane_port

// ===== lpt_port_properties.sv
// Purpose: Concurrent checks on the lane transceiver port pins
// Assumes: Cycles after a low ce are skipped by the data checks
// Notes: Bound from the testbench top file
`timescale 1ns/100ps
// ****************
// Port checker
// ****************
module lpt_port_properties #(
   parameter int LANE_COUNT = 4,
   parameter int BUF_STAT_W = 6
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [LANE_COUNT-1:0] tx_lane_off,
   input wire logic [LANE_COUNT-1:0] gttx_inhibit,
   input wire logic [32*LANE_COUNT-1:0] gttx_data,
   input wire logic [4*LANE_COUNT-1:0] gttx_charisk,
   input wire logic [32*LANE_COUNT-1:0] gtrx_data,
   input wire logic [32*LANE_COUNT-1:0] rx_word,
   input wire logic [4*LANE_COUNT-1:0] gtrx_charisk,
   input wire logic [4*LANE_COUNT-1:0] gtrx_chariscomma,
   input wire logic [LANE_COUNT-1:0] gtrx_chanbondseq,
   input wire logic [4*LANE_COUNT-1:0] rx_word_k,
   input wire logic [4*LANE_COUNT-1:0] rx_word_comma,
   input wire logic [LANE_COUNT-1:0] rx_bond_seq,
   input wire logic [4*LANE_COUNT-1:0] gtrx_disperr,
   input wire logic [4*LANE_COUNT-1:0] gtrx_notintable,
   input wire logic [4*LANE_COUNT-1:0] rx_byte_err,
   input wire logic gtrx_reset_req,
   input wire logic gtrx_reset,
   input wire logic rx_word_valid,
   input wire logic [BUF_STAT_W-1:0] buf_stat_in,
   input wire logic [BUF_STAT_W-1:0] buf_stat_out,
   input wire logic tx_flow_control,
   input wire logic tx_flow_mode,
   input wire logic [LANE_COUNT-1:0] lane_initialized
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   property p_inhibit;
      !$past(srst) && $past(ce) |-> gttx_inhibit == $past(tx_lane_off);
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("Inhibit mismatch");
   property p_rx_word;
      !$past(srst) && $past(ce) |-> rx_word == $past(gtrx_data);
   endproperty
   a_rx_word: assert property (p_rx_word) else $error("Receive word mismatch");
   property p_rx_flags;
      !$past(srst) && $past(ce) |-> rx_word_k == $past(gtrx_charisk)
         && rx_word_comma == $past(gtrx_chariscomma) && rx_bond_seq == $past(gtrx_chanbondseq);
   endproperty
   a_rx_flags: assert property (p_rx_flags) else $error("Receive flags mismatch");
   property p_byte_err;
      !$past(srst) && $past(ce) |-> rx_byte_err == $past(gtrx_disperr | gtrx_notintable);
   endproperty
   a_byte_err: assert property (p_byte_err) else $error("Byte error mismatch");
   property p_stat;
      !$past(srst) && $past(ce) |->
         buf_stat_out == ($past(buf_stat_in) > 30 ? 30 : $past(buf_stat_in));
   endproperty
   a_stat: assert property (p_stat) else $error("Buffer status not clamped");
   property p_mode;
      !$past(srst) && $past(ce) |-> tx_flow_mode == $past(tx_flow_control);
   endproperty
   a_mode: assert property (p_mode) else $error("Flow mode not followed");
   property p_req;
      gtrx_reset_req [*3] |-> ##[0:4] gtrx_reset;
   endproperty
   a_req: assert property (p_req) else $error("Reset request not served");
   property p_hide;
      gtrx_reset |-> !rx_word_valid;
   endproperty
   a_hide: assert property (p_hide) else $error("Receive valid during reset");
   property p_idle;
      gtrx_reset |-> gttx_data[31:0] == 32'h000000bc && gttx_charisk[3:0] == 4'h1;
   endproperty
   a_idle: assert property (p_idle) else $error("Transmit not idle in reset");
   property p_init;
      |lane_initialized |-> !gtrx_reset;
   endproperty
   a_init: assert property (p_init) else $error("Lane initialized during reset");
endmodule : lpt_port_properties

// ===== lpt_gt_model.sv
// Purpose: Behavioural serial transceiver pair for the port bench
// Assumes: Outputs change on the falling edge
// Notes: Receive data changes every cycle
`timescale 1ns/100ps
// ****************
// Transceiver model
// ****************
module lpt_gt_model #(
   parameter int LANE_COUNT = 2
) (
   input wire logic core_clk,
   input wire logic gtrx_reset,
   input wire logic gtrx_chanbonden,
   input wire logic req_cmd,
   output logic [32*LANE_COUNT-1:0] gtrx_data,
   output logic [4*LANE_COUNT-1:0] gtrx_charisk,
   output logic [4*LANE_COUNT-1:0] gtrx_chariscomma,
   output logic [LANE_COUNT-1:0] gtrx_chanbondseq,
   output logic [LANE_COUNT-1:0] gtrx_chanisaligned,
   output wire logic gtrx_reset_req,
   output logic [LANE_COUNT-1:0] gtrx_reset_done
);
   logic [31:0] cyc_reg = 32'h0;
   int done_wait = 0;
   int bond_wait = 0;
   assign gtrx_reset_req = req_cmd;
   // Lane data, flags, reset completion and alignment
   always @(negedge core_clk) begin
      cyc_reg <= cyc_reg + 32'h1;
      gtrx_data <= {LANE_COUNT{cyc_reg}};
      gtrx_charisk <= {LANE_COUNT{3'h0, cyc_reg[0]}};
      gtrx_chariscomma <= {LANE_COUNT{3'h0, cyc_reg[0]}};
      gtrx_chanbondseq <= {LANE_COUNT{cyc_reg[3:0] == 4'h0}};
      done_wait <= gtrx_reset ? 0 : done_wait + (done_wait < 8);
      gtrx_reset_done <= (done_wait == 8) ? '1 : '0;
      bond_wait <= gtrx_chanbonden ? bond_wait + (bond_wait < 3) : 0;
      gtrx_chanisaligned <= (bond_wait == 3) ? '1 : '0;
   end
endmodule : lpt_gt_model

// ===== testbench.sv
// Purpose: Self-checking bench for the lane transceiver port
// Assumes: Two lanes, inputs change on the falling edge
// Notes: Stream first, then table rows, initialization and reset request
`timescale 1ns/100ps
// ****************
// Bench top
// ****************
module testbench;
   localparam int LC = 2;
   localparam logic [63:0] IDLE = 64'h000000bc_000000bc;
   logic core_clk = 1'b0, srst = 1'b1, ce = 1'b1, tx_word_valid = 1'b0, req_cmd = 1'b0;
   logic [63:0] tx_word = '0, gttx_data, gtrx_data, rx_word;
   logic [7:0] tx_word_k = '0, gttx_charisk, gtrx_charisk, gtrx_chariscomma;
   logic [7:0] gtrx_disperr = '0, gtrx_notintable = '0, rx_word_k, rx_word_comma, rx_byte_err;
   logic [1:0] tx_lane_off = '0, gttx_inhibit, gtrx_chanbondseq, gtrx_chanisaligned;
   logic [1:0] gtrx_reset_done, rx_bond_seq, rx_status_good = '0, rx_status_bad = '0;
   logic [1:0] lane_initialized, port_state;
   logic [5:0] buf_stat_in = '0, buf_stat_out;
   logic tx_word_ready, gtrx_chanbonden, gtrx_reset_req, gtrx_reset, rx_word_valid;
   logic tx_flow_control = 1'b0, tx_flow_mode, tx_status_sent = 1'b0;
   int fail_count = 0, check_count = 0, cycles = 0, n;
   // Rows: status, flow, lane off, disparity, not-in-table -> status, mode, inhibit, error
   // Status inputs stay legal: never above 30, low five bits never all ones
   logic [24:0] row_in [6] = '{{6'h00, 1'h0, 2'h0, 8'h00, 8'h00}, {6'h1d, 1'h1, 2'h1, 8'h01, 8'h00},
      {6'h1e, 1'h0, 2'h2, 8'h00, 8'h80}, {6'h1e, 1'h1, 2'h3, 8'h0f, 8'hf0},
      {6'h15, 1'h0, 2'h0, 8'haa, 8'h55}, {6'h01, 1'h1, 2'h0, 8'h02, 8'h02}};
   logic [16:0] row_out [6] = '{{6'h00, 1'h0, 2'h0, 8'h00}, {6'h1d, 1'h1, 2'h1, 8'h01},
      {6'h1e, 1'h0, 2'h2, 8'h80}, {6'h1e, 1'h1, 2'h3, 8'hff},
      {6'h15, 1'h0, 2'h0, 8'hff}, {6'h01, 1'h1, 2'h0, 8'h02}};
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   lpt_lane_port #(.LANE_COUNT(LC)) i_dut (.core_clk, .srst, .ce, .tx_word, .tx_word_k,
      .tx_word_valid, .tx_word_ready, .tx_lane_off, .gttx_data, .gttx_charisk, .gttx_inhibit,
      .gtrx_data, .gtrx_charisk, .gtrx_chariscomma, .gtrx_disperr, .gtrx_notintable,
      .gtrx_chanbondseq, .gtrx_chanisaligned, .gtrx_chanbonden, .gtrx_reset_req, .gtrx_reset,
      .gtrx_reset_done, .rx_word, .rx_word_k, .rx_word_comma, .rx_byte_err, .rx_word_valid,
      .rx_bond_seq, .buf_stat_in, .tx_flow_control, .buf_stat_out, .tx_flow_mode,
      .tx_status_sent, .rx_status_good, .rx_status_bad, .lane_initialized, .port_state);
   lpt_gt_model #(.LANE_COUNT(LC)) i_gt (.core_clk, .gtrx_reset, .gtrx_chanbonden, .req_cmd,
      .gtrx_data, .gtrx_charisk, .gtrx_chariscomma, .gtrx_chanbondseq, .gtrx_chanisaligned,
      .gtrx_reset_req, .gtrx_reset_done);
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         fail_count++;
      end
   endtask : chk
   task close_out();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   task wait_run();
      n = 0;
      while (port_state !== 2'b11 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      chk(port_state, 2'b11);
      chk(gtrx_chanbonden, 1'b1);
   endtask : wait_run
   // Cycle ceiling against hangs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         close_out();
      end
   end
   // Main sequence
   initial begin
      repeat (4) @(negedge core_clk);
      chk({gtrx_reset, gtrx_chanbonden, port_state, tx_word_ready}, 5'h11);
      chk({gttx_data, gttx_charisk}, {IDLE, 8'h11});
      srst = 1'b0;
      // Queue 16 words before the link runs, then expect refusal
      for (int i = 0; i < 16; i++) begin
         chk(tx_word_ready, 1'b1);
         tx_word_valid = 1'b1;
         tx_word = {32'h20000000 + i, 32'h10000000 + i};
         tx_word_k = 8'h10;
         @(negedge core_clk);
      end
      tx_word_valid = 1'b0;
      chk(tx_word_ready, 1'b0);
      wait_run();
      n = 0;
      for (int c = 0; c < 60 && n < 16; c++) begin
         if (gttx_data !== IDLE) begin
            chk({gttx_data, gttx_charisk}, {32'h20000000 + n, 32'h10000000 + n, 8'h10});
            n++;
         end
         @(negedge core_clk);
      end
      chk(n, 16);
      // Table of level paths
      for (int r = 0; r < 6; r++) begin
         {buf_stat_in, tx_flow_control, tx_lane_off, gtrx_disperr, gtrx_notintable} = row_in[r];
         @(negedge core_clk);
         chk({buf_stat_out, tx_flow_mode, gttx_inhibit, rx_byte_err}, row_out[r]);
      end
      // Status counts: 14 sent is one short, 15 completes
      for (int i = 0; i < 15; i++) begin
         if (i == 14) chk(lane_initialized, 2'b00);
         tx_status_sent = 1'b1;
         rx_status_good = (i < 8) ? 2'b11 : 2'b00;
         @(negedge core_clk);
         {tx_status_sent, rx_status_good} = '0;
         @(negedge core_clk);
      end
      chk(lane_initialized, 2'b11);
      rx_status_bad = 2'b10;
      @(negedge core_clk);
      rx_status_bad = 2'b00;
      @(negedge core_clk);
      chk(lane_initialized, 2'b01);
      // Clock enable low freezes outputs and state
      ce = 1'b0;
      tx_lane_off = 2'b11;
      repeat (2) @(negedge core_clk);
      chk({gttx_inhibit, port_state, lane_initialized}, 6'h0d);
      ce = 1'b1;
      @(negedge core_clk);
      chk(gttx_inhibit, 2'b11);
      tx_lane_off = 2'b00;
      // Transceiver reset request mid-run
      req_cmd = 1'b1;
      repeat (4) @(negedge core_clk);
      req_cmd = 1'b0;
      chk({gtrx_reset, rx_word_valid, lane_initialized}, 4'h8);
      wait_run();
      chk(rx_word_valid, 1'b1);
      close_out();
   end
endmodule : testbench
bind lpt_lane_port lpt_port_properties #(.LANE_COUNT(LANE_COUNT), .BUF_STAT_W(BUF_STAT_W))
   i_props (.core_clk, .srst, .ce, .tx_lane_off, .gttx_inhibit, .gttx_data, .gttx_charisk,
   .gtrx_data, .rx_word, .gtrx_charisk, .gtrx_chariscomma, .gtrx_chanbondseq, .rx_word_k,
   .rx_word_comma, .rx_bond_seq, .gtrx_disperr, .gtrx_notintable, .rx_byte_err, .gtrx_reset_req,
   .gtrx_reset, .rx_word_valid, .buf_stat_in, .buf_stat_out, .tx_flow_control, .tx_flow_mode,
   .lane_initialized);
